//--- src/gprm_params.svh
// register offsets, address windows and reset values for the four-port gpio register map
`ifndef GPRM_PARAMS_SVH
`define GPRM_PARAMS_SVH

`define GPRM_PORT_W 8
`define GPRM_NUM_PORTS 4
`define GPRM_ADDR_W 16
`define GPRM_IO_OFF_W 6

// i/o-space window and the data-space aliases
`define GPRM_IO_LAST 16'h003f
`define GPRM_DS_IO_BASE 16'h0020
`define GPRM_DS_EXT_BASE 16'h0060

// port d sits lowest; each port above it is three locations higher
`define GPRM_OFF_D_SENSE 6'h10
`define GPRM_OFF_D_DIR 6'h11
`define GPRM_OFF_D_LATCH 6'h12
`define GPRM_OFF_C_SENSE 6'h13
`define GPRM_OFF_C_DIR 6'h14
`define GPRM_OFF_C_LATCH 6'h15
`define GPRM_OFF_B_SENSE 6'h16
`define GPRM_OFF_B_DIR 6'h17
`define GPRM_OFF_B_LATCH 6'h18
`define GPRM_OFF_A_SENSE 6'h19
`define GPRM_OFF_A_DIR 6'h1a
`define GPRM_OFF_A_LATCH 6'h1b
`define GPRM_OFF_STRIDE 6'h03

// port indices
`define GPRM_IDX_A 2'h0
`define GPRM_IDX_B 2'h1
`define GPRM_IDX_C 2'h2
`define GPRM_IDX_D 2'h3

// reset values
`define GPRM_RST_DIR 8'h00
`define GPRM_RST_LATCH 8'h00
`define GPRM_RST_SENSE 8'h00
`define GPRM_RST_RDATA 8'h00
`define GPRM_UNMAPPED_RDATA 8'h00
`define GPRM_ALL_OUT 8'hff
`define GPRM_ALL_IN 8'h00
`define GPRM_FORCED_LEVEL 8'h00

`endif

//--- src/gprm_pkg.sv
// types shared by the gpio register map modules
`include "gprm_params.svh"
package gprm_pkg;

    typedef enum logic [1:0] {
        GPRM_SEL_SENSE = 2'h0,
        GPRM_SEL_DIR = 2'h1,
        GPRM_SEL_LATCH = 2'h2
    } gprm_sel_t;

    typedef struct packed {
        logic [`GPRM_PORT_W-1:0] dir;
        logic [`GPRM_PORT_W-1:0] latch;
        logic [`GPRM_PORT_W-1:0] sync1;
        logic [`GPRM_PORT_W-1:0] sense;
        logic [`GPRM_PORT_W-1:0] pull;
    } gprm_port_state_t;

    typedef struct packed {
        logic [`GPRM_PORT_W-1:0] rdata;
        logic rvalid;
    } gprm_top_state_t;

endpackage : gprm_pkg

//--- src/gprm_acc_if.sv
// decoded register access passed from the address decoder to the ports
`include "gprm_params.svh"
interface gprm_acc_if;
    logic hit;
    logic [1:0] port;
    gprm_pkg::gprm_sel_t sel;
    logic we;
    logic [`GPRM_PORT_W-1:0] wdata;

    modport dec (output hit, output port, output sel, output we, output wdata);
    modport prt (input hit, input port, input sel, input we, input wdata);
endinterface : gprm_acc_if

//--- src/gprm_decode.sv
// maps an i/o-space or data-space access onto a port and register
`include "gprm_params.svh"
module gprm_decode (
    // access request
    input wire logic i_valid,
    input wire logic i_data_space,
    input wire logic i_write,
    input wire logic [`GPRM_ADDR_W-1:0] i_addr,
    input wire logic [`GPRM_PORT_W-1:0] i_wdata,
    // decoded access
    gprm_acc_if.dec acc
);

    // offset of the first register of port p, port d being the lowest
    function automatic logic [`GPRM_IO_OFF_W-1:0] port_base(input logic [1:0] p);
        logic [`GPRM_IO_OFF_W-1:0] steps;
        steps = `GPRM_IO_OFF_W'(`GPRM_IDX_D - p);
        return `GPRM_IO_OFF_W'(`GPRM_OFF_D_SENSE + steps * `GPRM_OFF_STRIDE);
    endfunction : port_base

    logic off_ok;
    logic [`GPRM_IO_OFF_W-1:0] off;
    logic [`GPRM_ADDR_W-1:0] ds_rel;

    always_comb begin
        ds_rel = i_addr - `GPRM_DS_IO_BASE;
        off_ok = 1'b0;
        off = '0;
        if (i_data_space) begin
            // only the aliased window maps to ports; the extended region holds nothing here
            if (i_addr >= `GPRM_DS_IO_BASE && i_addr < `GPRM_DS_EXT_BASE) begin
                off_ok = 1'b1;
                off = ds_rel[`GPRM_IO_OFF_W-1:0];
            end
        end else if (i_addr <= `GPRM_IO_LAST) begin
            off_ok = 1'b1;
            off = i_addr[`GPRM_IO_OFF_W-1:0];
        end
    end

    always_comb begin
        acc.hit = 1'b0;
        acc.port = `GPRM_IDX_A;
        acc.sel = gprm_pkg::GPRM_SEL_SENSE;
        acc.we = i_write;
        acc.wdata = i_wdata;
        for (int p = 0; p < `GPRM_NUM_PORTS; p++) begin
            if (i_valid && off_ok && off >= port_base(2'(p)) && off < port_base(2'(p)) + `GPRM_OFF_STRIDE) begin
                acc.hit = 1'b1;
                acc.port = 2'(p);
                acc.sel = gprm_pkg::gprm_sel_t'(2'(off - port_base(2'(p))));
            end
        end
    end

endmodule : gprm_decode

//--- src/gprm_port.sv
// one 8-bit port: direction, output latch, pin sampler, pad drive and pull-up
`include "gprm_params.svh"
module gprm_port #(
    parameter logic [1:0] PORT_IDX = `GPRM_IDX_A,
    parameter bit COMPAT_FORCE = 1'b0
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    // static configuration
    input wire logic i_compat,
    input wire logic i_pullup_off,
    // decoded access
    gprm_acc_if.prt acc,
    // pad
    input wire logic [`GPRM_PORT_W-1:0] i_pin,
    output logic [`GPRM_PORT_W-1:0] o_pin_out,
    output logic [`GPRM_PORT_W-1:0] o_pin_oe_n,
    output logic [`GPRM_PORT_W-1:0] o_pull_en,
    // readback
    output logic [`GPRM_PORT_W-1:0] o_dir,
    output logic [`GPRM_PORT_W-1:0] o_latch,
    output logic [`GPRM_PORT_W-1:0] o_sense
);

    gprm_pkg::gprm_port_state_t state_r;
    gprm_pkg::gprm_port_state_t state_nxt;
    logic sel_me;

    always_comb begin
        state_nxt = state_r;
        sel_me = acc.hit && acc.we && acc.port == PORT_IDX;
        state_nxt.sync1 = i_pin;
        state_nxt.sense = state_r.sync1;
        if (sel_me && acc.sel == gprm_pkg::GPRM_SEL_DIR) begin
            state_nxt.dir = acc.wdata;
        end
        if (sel_me && acc.sel == gprm_pkg::GPRM_SEL_LATCH) begin
            state_nxt.latch = acc.wdata;
        end
        // a write to the sense location falls through untouched
        state_nxt.pull = ~state_nxt.dir & state_nxt.latch & {`GPRM_PORT_W{~i_pullup_off}};
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            state_r.dir <= `GPRM_RST_DIR;
            state_r.latch <= `GPRM_RST_LATCH;
            state_r.sync1 <= `GPRM_RST_SENSE;
            state_r.sense <= `GPRM_RST_SENSE;
            state_r.pull <= `GPRM_ALL_IN;
        end else if (i_ce) begin
            state_r <= state_nxt;
        end
    end

    // the forced port is gated by the fuse level alone so it holds before any clock edge
    generate
        if (COMPAT_FORCE) begin : g_forced
            assign o_pin_oe_n = i_compat ? `GPRM_ALL_IN : ~state_r.dir;
            // a constant level: the latch holds nothing defined until the first clocked reset
            assign o_pin_out = i_compat ? `GPRM_FORCED_LEVEL : state_r.latch;
            assign o_pull_en = i_compat ? `GPRM_ALL_IN : state_r.pull;
        end else begin : g_plain
            assign o_pin_oe_n = ~state_r.dir;
            assign o_pin_out = state_r.latch;
            assign o_pull_en = state_r.pull;
        end
    endgenerate

    assign o_dir = state_r.dir;
    assign o_latch = state_r.latch;
    assign o_sense = state_r.sense;

endmodule : gprm_port

//--- src/gprm_top.sv
// four-port gpio register map reached by short i/o and data-space operations
`include "gprm_params.svh"
module gprm_top (
    // clock, reset, clock enable
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    // static configuration
    input wire logic i_compat_mode,
    input wire logic i_global_pullup_disable,
    // core access
    input wire logic i_acc_valid,
    input wire logic i_acc_data_space,
    input wire logic i_acc_write,
    input wire logic [`GPRM_ADDR_W-1:0] i_acc_addr,
    input wire logic [`GPRM_PORT_W-1:0] i_acc_wdata,
    output logic [`GPRM_PORT_W-1:0] o_acc_rdata,
    output logic o_acc_rvalid,
    // port a pad
    input wire logic [`GPRM_PORT_W-1:0] i_pa_pin,
    output logic [`GPRM_PORT_W-1:0] o_pa_out,
    output logic [`GPRM_PORT_W-1:0] o_pa_oe_n,
    output logic [`GPRM_PORT_W-1:0] o_pa_pull_en,
    // port b pad
    input wire logic [`GPRM_PORT_W-1:0] i_pb_pin,
    output logic [`GPRM_PORT_W-1:0] o_pb_out,
    output logic [`GPRM_PORT_W-1:0] o_pb_oe_n,
    output logic [`GPRM_PORT_W-1:0] o_pb_pull_en,
    // port c pad
    input wire logic [`GPRM_PORT_W-1:0] i_pc_pin,
    output logic [`GPRM_PORT_W-1:0] o_pc_out,
    output logic [`GPRM_PORT_W-1:0] o_pc_oe_n,
    output logic [`GPRM_PORT_W-1:0] o_pc_pull_en,
    // port d pad
    input wire logic [`GPRM_PORT_W-1:0] i_pd_pin,
    output logic [`GPRM_PORT_W-1:0] o_pd_out,
    output logic [`GPRM_PORT_W-1:0] o_pd_oe_n,
    output logic [`GPRM_PORT_W-1:0] o_pd_pull_en
);

    gprm_acc_if acc ();

    logic [`GPRM_PORT_W-1:0] pin_in [`GPRM_NUM_PORTS];
    logic [`GPRM_PORT_W-1:0] pin_out [`GPRM_NUM_PORTS];
    logic [`GPRM_PORT_W-1:0] pin_oe_n [`GPRM_NUM_PORTS];
    logic [`GPRM_PORT_W-1:0] pull_en [`GPRM_NUM_PORTS];
    logic [`GPRM_PORT_W-1:0] rb_dir [`GPRM_NUM_PORTS];
    logic [`GPRM_PORT_W-1:0] rb_latch [`GPRM_NUM_PORTS];
    logic [`GPRM_PORT_W-1:0] rb_sense [`GPRM_NUM_PORTS];

    gprm_pkg::gprm_top_state_t state_r;
    gprm_pkg::gprm_top_state_t state_nxt;

    gprm_decode u_decode (
        .i_valid(i_acc_valid),
        .i_data_space(i_acc_data_space),
        .i_write(i_acc_write),
        .i_addr(i_acc_addr),
        .i_wdata(i_acc_wdata),
        .acc(acc.dec)
    );

    assign pin_in[`GPRM_IDX_A] = i_pa_pin;
    assign pin_in[`GPRM_IDX_B] = i_pb_pin;
    assign pin_in[`GPRM_IDX_C] = i_pc_pin;
    assign pin_in[`GPRM_IDX_D] = i_pd_pin;

    // only port c carries the compatibility override
    generate
        for (genvar p = 0; p < `GPRM_NUM_PORTS; p++) begin : g_port
            gprm_port #(
                .PORT_IDX(2'(p)),
                .COMPAT_FORCE(2'(p) == `GPRM_IDX_C)
            ) u_port (
                .i_clk(i_clk),
                .i_rst_n(i_rst_n),
                .i_ce(i_ce),
                .i_compat(i_compat_mode),
                .i_pullup_off(i_global_pullup_disable),
                .acc(acc.prt),
                .i_pin(pin_in[p]),
                .o_pin_out(pin_out[p]),
                .o_pin_oe_n(pin_oe_n[p]),
                .o_pull_en(pull_en[p]),
                .o_dir(rb_dir[p]),
                .o_latch(rb_latch[p]),
                .o_sense(rb_sense[p])
            );
        end
    endgenerate

    // read answer one cycle after the request; unmapped or extended addresses read zero
    always_comb begin
        state_nxt = state_r;
        state_nxt.rvalid = i_acc_valid && !i_acc_write;
        if (i_acc_valid && !i_acc_write) begin
            state_nxt.rdata = `GPRM_UNMAPPED_RDATA;
            if (acc.hit) begin
                case (acc.sel)
                    gprm_pkg::GPRM_SEL_SENSE: state_nxt.rdata = rb_sense[acc.port];
                    gprm_pkg::GPRM_SEL_DIR: state_nxt.rdata = rb_dir[acc.port];
                    gprm_pkg::GPRM_SEL_LATCH: state_nxt.rdata = rb_latch[acc.port];
                    default: state_nxt.rdata = `GPRM_UNMAPPED_RDATA;
                endcase
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            state_r.rdata <= `GPRM_RST_RDATA;
            state_r.rvalid <= 1'b0;
        end else if (i_ce) begin
            state_r <= state_nxt;
        end
    end

    assign o_acc_rdata = state_r.rdata;
    assign o_acc_rvalid = state_r.rvalid;

    // pad outputs come from the port flops; port c adds only the fuse gating
    assign o_pa_out = pin_out[`GPRM_IDX_A];
    assign o_pa_oe_n = pin_oe_n[`GPRM_IDX_A];
    assign o_pa_pull_en = pull_en[`GPRM_IDX_A];
    assign o_pb_out = pin_out[`GPRM_IDX_B];
    assign o_pb_oe_n = pin_oe_n[`GPRM_IDX_B];
    assign o_pb_pull_en = pull_en[`GPRM_IDX_B];
    assign o_pc_out = pin_out[`GPRM_IDX_C];
    assign o_pc_oe_n = pin_oe_n[`GPRM_IDX_C];
    assign o_pc_pull_en = pull_en[`GPRM_IDX_C];
    assign o_pd_out = pin_out[`GPRM_IDX_D];
    assign o_pd_oe_n = pin_oe_n[`GPRM_IDX_D];
    assign o_pd_pull_en = pull_en[`GPRM_IDX_D];

endmodule : gprm_top

//--- tb/gprm_top_asserts.sv
// concurrent checks on the gpio register map top-level ports
module gprm_chk (
    // clock, reset, enable
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    // configuration and access
    input wire logic i_compat_mode,
    input wire logic i_global_pullup_disable,
    input wire logic i_acc_valid,
    input wire logic i_acc_data_space,
    input wire logic i_acc_write,
    input wire logic [15:0] i_acc_addr,
    input wire logic [7:0] i_acc_wdata,
    // watched outputs
    input wire logic [7:0] o_acc_rdata,
    input wire logic o_acc_rvalid,
    input wire logic [7:0] o_pa_out,
    input wire logic [7:0] o_pa_oe_n,
    input wire logic [7:0] o_pa_pull_en,
    input wire logic [7:0] o_pb_oe_n,
    input wire logic [7:0] o_pc_oe_n,
    input wire logic [7:0] o_pc_out,
    input wire logic [7:0] o_pc_pull_en,
    input wire logic [7:0] o_pd_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic rd_go;
    logic wr_go;
    assign rd_go = i_ce && i_acc_valid && !i_acc_write;
    assign wr_go = i_ce && i_acc_valid && i_acc_write;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    a_read_answer: assert property (rd_go |=> o_acc_rvalid) else $error("read not answered");
    // a frozen clock enable keeps the last answer standing, so only enabled edges are judged
    a_answer_cause: assert property (o_acc_rvalid && $past(i_ce) |-> $past(rd_go))
        else $error("answer without read");
    a_io_window: assert property (rd_go && !i_acc_data_space && i_acc_addr > 16'h003f |=> o_acc_rdata == 8'h00)
        else $error("short op outside window returned data");
    a_ext_region: assert property (rd_go && i_acc_data_space && i_acc_addr >= 16'h0060 |=> o_acc_rdata == 8'h00)
        else $error("extended region read returned data");
    a_dir_alias: assert property (wr_go && i_acc_addr == (i_acc_data_space ? 16'h0037 : 16'h0017)
        |=> o_pb_oe_n == ~$past(i_acc_wdata)) else $error("port b direction write not on pads");
    a_latch_drive: assert property (wr_go && i_acc_addr == (i_acc_data_space ? 16'h0032 : 16'h0012)
        |=> o_pd_out == $past(i_acc_wdata)) else $error("port d latch write not on pads");
    a_pull_rule: assert property (i_ce && $past(i_ce) && $stable(o_pa_oe_n) && $stable(o_pa_out)
        && $stable(i_global_pullup_disable) |-> o_pa_pull_en == (o_pa_oe_n & o_pa_out & {8{!i_global_pullup_disable}}))
        else $error("port a pull-up enable wrong");
    // checked through reset too: the forced state must not wait for a clocked reset
    a_compat_force: assert property (disable iff (1'b0) i_compat_mode |-> o_pc_oe_n == 8'h00
        && o_pc_pull_en == 8'h00 && o_pc_out == 8'h00) else $error("port c not forced to drive zero");
    a_rdata_hold: assert property ($past(i_rst_n) && !o_acc_rvalid |-> $stable(o_acc_rdata))
        else $error("read data moved without answer");
    a_ce_freeze: assert property (!i_ce |=> $stable(o_pb_oe_n) && $stable(o_pd_out))
        else $error("state moved with clock enable low");
    c_ds_read: cover property (rd_go && i_acc_data_space);
    c_io_write: cover property (wr_go && !i_acc_data_space);
    c_ce_low: cover property (!i_ce && i_acc_valid);
endmodule : gprm_chk

bind gprm_top gprm_chk u_gprm_chk (.*);

//--- tb/gprm_board.sv
// board model of the 32 pad lines, ports d..a from the top byte down
module gprm_board (
    // device pads
    input wire logic [31:0] i_out,
    input wire logic [31:0] i_oe_n,
    // board source, always driving so released pads never float
    input wire logic [31:0] i_ext,
    output logic [31:0] o_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    assign o_pin = (~i_oe_n & i_out) | (i_oe_n & i_ext);
endmodule : gprm_board

//--- tb/tb.sv
// self-checking bench for the gpio register map
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk, i_rst_n, i_ce, i_compat_mode, i_global_pullup_disable;
    logic i_acc_valid, i_acc_data_space, i_acc_write, o_acc_rvalid;
    logic [15:0] i_acc_addr;
    logic [7:0] i_acc_wdata, o_acc_rdata, i_pa_pin, i_pb_pin, i_pc_pin, i_pd_pin, d;
    logic [7:0] o_pa_out, o_pa_oe_n, o_pa_pull_en, o_pb_out, o_pb_oe_n, o_pb_pull_en;
    logic [7:0] o_pc_out, o_pc_oe_n, o_pc_pull_en, o_pd_out, o_pd_oe_n, o_pd_pull_en;
    logic [31:0] ext, pins;
    logic [7:0] dir_m [4];
    logic [7:0] lat_m [4];
    logic [15:0] bad [8] = '{16'h0040, 16'h005a, 16'h001c, 16'h000f, 16'h0015, 16'h0060, 16'h007a, 16'hffff};
    bit bad_ds [8] = '{0, 0, 0, 0, 1, 1, 1, 1};
    int error_cnt, comparisons, p, sel;
    bit ds;
    wire [31:0] oe_all = {o_pd_oe_n, o_pc_oe_n, o_pb_oe_n, o_pa_oe_n};
    wire [31:0] out_all = {o_pd_out, o_pc_out, o_pb_out, o_pa_out};
    wire [31:0] pull_all = {o_pd_pull_en, o_pc_pull_en, o_pb_pull_en, o_pa_pull_en};

    gprm_top u_gprm_top (.*);
    gprm_board u_gprm_board (
        .i_out(out_all),
        .i_oe_n(oe_all),
        .i_ext(ext),
        .o_pin(pins)
    );
    assign {i_pd_pin, i_pc_pin, i_pb_pin, i_pa_pin} = pins;

    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end

    function automatic logic [15:0] addr_of(int port, int s, bit space);
        return 16'(8'h19 - 8'(3 * port) + 8'(s)) + (space ? 16'h0020 : 16'h0000);
    endfunction : addr_of

    task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // leaves valid up so accesses can run back to back; idle lowers it
    task automatic put(bit space, bit we, logic [15:0] a, logic [7:0] wd);
        i_acc_valid = 1'b1;
        i_acc_data_space = space;
        i_acc_write = we;
        i_acc_addr = a;
        i_acc_wdata = wd;
        @(posedge i_clk);
        #2;
    endtask : put

    task automatic idle(int n);
        i_acc_valid = 1'b0;
        repeat (n) @(posedge i_clk);
        #2;
    endtask : idle

    task automatic rd(string name, bit space, logic [15:0] a, logic [7:0] exp);
        put(space, 1'b0, a, 8'h00);
        chk({name, " valid"}, 8'h01, {7'h00, o_acc_rvalid});
        chk(name, exp, o_acc_rdata);
    endtask : rd

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : print_verdict

    initial begin
        repeat (3000) @(posedge i_clk);
        error_cnt++;
        $display("mismatch watchdog expected finish seen timeout");
        print_verdict();
    end

    initial begin
        void'($urandom(32'h5899));
        {i_rst_n, i_ce, i_global_pullup_disable, i_acc_valid, i_acc_data_space, i_acc_write} = '0;
        i_compat_mode = 1'b1;
        i_acc_addr = 16'h0000;
        i_acc_wdata = 8'h00;
        ext = $urandom();
        // before any clock edge: no port c access while forced
        #5;
        chk("compat oe_n", 8'h00, o_pc_oe_n);
        chk("compat out", 8'h00, o_pc_out);
        i_ce = 1'b1;
        repeat (2) @(posedge i_clk);
        #2;
        i_rst_n = 1'b1;
        i_compat_mode = 1'b0;
        $display("test compat done");
        for (p = 0; p < 4; p++) begin
            dir_m[p] = 8'h00;
            lat_m[p] = 8'h00;
            chk("reset oe_n", 8'hff, oe_all[p*8 +: 8]);
            chk("reset out", 8'h00, out_all[p*8 +: 8]);
            rd("reset dir", 1'b0, addr_of(p, 1, 1'b0), 8'h00);
            rd("reset latch", 1'b1, addr_of(p, 2, 1'b1), 8'h00);
        end
        $display("test reset done");
        for (int n = 0; n < 40; n++) begin
            p = $urandom_range(3);
            sel = $urandom_range(2, 1);
            ds = 1'($urandom_range(1));
            d = (n < 4) ? {8{n[0]}} : 8'($urandom());
            i_global_pullup_disable = 1'($urandom_range(1));
            ext = $urandom();
            put(ds, 1'b1, addr_of(p, sel, ds), d);
            if (sel == 1) dir_m[p] = d;
            else lat_m[p] = d;
            rd("readback", !ds, addr_of(p, sel, !ds), d);
            put(ds, 1'b1, addr_of(p, 0, ds), ~d);
            idle(4);
            chk("oe_n", ~dir_m[p], oe_all[p*8 +: 8]);
            chk("out", lat_m[p], out_all[p*8 +: 8]);
            chk("pull", ~dir_m[p] & lat_m[p] & {8{!i_global_pullup_disable}}, pull_all[p*8 +: 8]);
            rd("sense", ds, addr_of(p, 0, ds), (dir_m[p] & lat_m[p]) | (~dir_m[p] & ext[p*8 +: 8]));
        end
        $display("test random done");
        foreach (bad[i]) begin
            put(bad_ds[i], 1'b1, bad[i], 8'hff);
            rd("refused", bad_ds[i], bad[i], 8'h00);
        end
        i_ce = 1'b0;
        put(1'b0, 1'b1, addr_of(0, 1, 1'b0), ~dir_m[0]);
        i_ce = 1'b1;
        for (p = 0; p < 4; p++) begin
            rd("kept dir", 1'b1, addr_of(p, 1, 1'b1), dir_m[p]);
            rd("kept latch", 1'b0, addr_of(p, 2, 1'b0), lat_m[p]);
        end
        idle(1);
        $display("test refused done");
        print_verdict();
    end
endmodule : tb
